// File: common/focr_pkg.sv
package focr_pkg;
  localparam int unsigned FOCR_AW = 8;
  localparam logic [7:0] FOCR_CTRL_OFS = 8'h14;
  localparam logic [7:0] FOCR_OPT_OFS = 8'h20;
  localparam logic [7:0] FOCR_AREA_OFS = 8'h24;
  localparam logic [7:0] FOCR_WPM_OFS = 8'h2c;
  localparam logic [7:0] FOCR_LOAD_OFS = 8'h30;
  localparam int unsigned FOCR_PG_BIT = 0;
  localparam int unsigned FOCR_PER_BIT = 1;
  localparam int unsigned FOCR_MER_BIT = 2;
  localparam int unsigned FOCR_SER_BIT = 11;
  localparam int unsigned FOCR_RLD_BIT = 27;
  localparam logic [31:0] FOCR_CTRL_MASK = 32'h0800_0807;
  localparam logic [31:0] FOCR_OPT_MASK = 32'h0000_ffff;
  localparam logic [31:0] FOCR_AREA_MASK = 32'h0000_1f1f;
  localparam logic [31:0] FOCR_WPM_MASK = 32'h0000_ffff;
  localparam logic [7:0] FOCR_RDP_OPEN = 8'haa;
  localparam logic [15:0] FOCR_WPM_NONE = 16'hffff;
  localparam int unsigned FOCR_STEP_SHIFT = 11;
  localparam logic [3:0] FOCR_LOAD_CYC = 4'h4;

  typedef struct packed {
    logic boot_select_bit;
    logic reset_pin_function;
    logic window_dog_soft_start;
    logic independent_dog_soft_start;
    logic [2:0] brownout_level;
    logic brownout_enable;
    logic [7:0] read_protect_level;
  } focr_opt_t;

  typedef struct packed {
    logic [4:0] protected_area_end;
    logic [4:0] protected_area_start;
  } focr_area_t;

  typedef struct packed {
    logic program_select;
    logic page_erase_select;
    logic sector_erase_select;
    logic mass_erase_select;
  } focr_op_t;

  typedef enum logic [1:0] {
    FOCR_ST_IDLE = 2'b00,
    FOCR_ST_LOAD = 2'b01,
    FOCR_ST_DONE = 2'b10
  } focr_state_t;
endpackage

// File: hdl/focr_guard.sv
`timescale 1ns/10ps
module focr_guard #(
  parameter int unsigned SECTORS = 16
) (
  input focr_pkg::focr_op_t op,
  input wire logic [3:0] sector,
  input wire logic info_target,
  input wire logic [SECTORS-1:0] wpm,
  output logic [SECTORS-1:0] sector_open,
  output focr_pkg::focr_op_t allowed
);
  import focr_pkg::*;
  // ***************************************
  // per-sector protection decode
  // ***************************************
  genvar g;
  generate
    for (g = 0; g < SECTORS; g++) begin : g_sec
      assign sector_open[g] = wpm[g];
    end
  endgenerate
  wire any_protect = ~&wpm;
  wire target_open = sector_open[sector];
  assign allowed.program_select = op.program_select;
  assign allowed.page_erase_select = op.page_erase_select;
  assign allowed.sector_erase_select = op.sector_erase_select
    & ~info_target & target_open;
  assign allowed.mass_erase_select = op.mass_erase_select
    & ~info_target & ~any_protect;
endmodule

// File: hdl/focr_loader.sv
`timescale 1ns/10ps
module focr_loader (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  output logic load_strobe,
  output logic busy
);
  import focr_pkg::*;
  focr_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  // ***************************************
  // option byte fetch sequencer
  // ***************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      FOCR_ST_IDLE: begin
        if (start) begin
          state_d = FOCR_ST_LOAD;
          cnt_d = FOCR_LOAD_CYC;
        end
      end
      FOCR_ST_LOAD: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          state_d = FOCR_ST_DONE;
        end
      end
      FOCR_ST_DONE: state_d = FOCR_ST_IDLE;
      default: state_d = FOCR_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= FOCR_ST_LOAD;
      cnt_q <= FOCR_LOAD_CYC;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  assign load_strobe = (state_q == FOCR_ST_DONE);
  assign busy = (state_q != FOCR_ST_IDLE);
endmodule

// File: hdl/focr_top.sv
`timescale 1ns/10ps
// Operation
// - sector erase never touches information memory
// - sector erase skips write-protected sectors
// - control bit 2 selects mass erase
// - mass erase blocked by any write protection
// - control bit 1 selects page erase
// - control bit 0 selects program
// - option register loaded at reset release
// - protected-area register loaded at reset release
// - option bit 15 selects boot mode with pin
// - option bit 14 sets reset pin function
// - bits 13,12 choose watchdog start mode
// - three-bit brownout level picks threshold pair
// - bit 8 enables brownout; level needs it
// - read protection open only at 0xaa
// - protected-area end in 2 kbyte steps
// - protected-area start in 2 kbyte steps
// - control bit 11 selects sector erase
// - reload request reloads, clears when done
module focr_top #(
  parameter int unsigned SECTORS = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [focr_pkg::FOCR_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input focr_pkg::focr_opt_t nv_opt,
  input focr_pkg::focr_area_t nv_area,
  input wire logic [SECTORS-1:0] nv_wpm,
  input wire logic boot_pin,
  input wire logic [3:0] target_sector,
  input wire logic target_info,
  output focr_pkg::focr_op_t op_allowed,
  output logic [SECTORS-1:0] write_protect_mask,
  output logic boot_from_system,
  output logic reset_pin_function,
  output logic window_dog_soft_start,
  output logic independent_dog_soft_start,
  output logic brownout_enable,
  output logic [2:0] brownout_level,
  output logic read_protect_active,
  output logic [31:0] area_first_addr,
  output logic [31:0] area_last_addr,
  output logic option_reload_reset
);
  import focr_pkg::*;

  // ***************************************
  // registers
  // ***************************************
  logic [31:0] ctrl_q;
  focr_opt_t opt_q;
  focr_area_t area_q;
  logic [SECTORS-1:0] wpm_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic boot_s1_q, boot_s2_q;
  logic [SECTORS-1:0] nv_wpm_s1_q, nv_wpm_s2_q;
  focr_opt_t nv_opt_s1_q, nv_opt_s2_q;
  focr_area_t nv_area_s1_q, nv_area_s2_q;

  // ***************************************
  // loader
  // ***************************************
  wire load_strobe;
  wire load_busy;
  // a reload request is held until the fetch is done
  wire reload_req = ctrl_q[FOCR_RLD_BIT] & ~load_busy;

  focr_loader u_loader (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(reload_req),
    .load_strobe(load_strobe),
    .busy(load_busy)
  );

  // ***************************************
  // bus decode
  // ***************************************
  wire sel_ctrl = (avs_address == FOCR_CTRL_OFS);
  wire sel_opt = (avs_address == FOCR_OPT_OFS);
  wire sel_area = (avs_address == FOCR_AREA_OFS);
  wire sel_wpm = (avs_address == FOCR_WPM_OFS);
  wire sel_load = (avs_address == FOCR_LOAD_OFS);
  // one wait state: answer on the cycle after the request is seen
  wire req = (avs_read | avs_write) & ~ack_q;
  wire wr = avs_write & ack_q & ce;
  wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // writes are blocked while the option fetch runs
  wire wr_ok = wr & ~load_busy;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] bm,
                                        input logic [31:0] keep);
    merge = ((old & ~bm) | (nw & bm)) & keep;
  endfunction

  wire [31:0] opt_word = {16'h0000, opt_q};
  wire [31:0] area_word = {19'h0, area_q.protected_area_end, 3'h0,
                           area_q.protected_area_start};
  wire [31:0] wpm_word = 32'(wpm_q);
  wire [31:0] ctrl_new = merge(ctrl_q, avs_writedata, bmask,
                               FOCR_CTRL_MASK);
  wire [31:0] opt_new = merge(opt_word, avs_writedata, bmask,
                              FOCR_OPT_MASK);
  wire [31:0] area_new = merge(area_word, avs_writedata, bmask,
                               FOCR_AREA_MASK);
  wire [31:0] wpm_new = merge(wpm_word, avs_writedata, bmask,
                              FOCR_WPM_MASK);

  wire [31:0] rd_mux = sel_ctrl ? (ctrl_q & FOCR_CTRL_MASK) :
                       sel_opt ? opt_word :
                       sel_area ? area_word :
                       sel_wpm ? wpm_word :
                       sel_load ? {31'h0, load_busy} :
                       32'h0000_0000;

  // ***************************************
  // synchronisers for pins and stored bytes
  // ***************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_s1_q <= 1'b0;
      boot_s2_q <= 1'b0;
      nv_opt_s1_q <= '0;
      nv_opt_s2_q <= '0;
      nv_area_s1_q <= '0;
      nv_area_s2_q <= '0;
      nv_wpm_s1_q <= '0;
      nv_wpm_s2_q <= '0;
    end else if (ce) begin
      boot_s1_q <= boot_pin;
      boot_s2_q <= boot_s1_q;
      nv_opt_s1_q <= nv_opt;
      nv_opt_s2_q <= nv_opt_s1_q;
      nv_area_s1_q <= nv_area;
      nv_area_s2_q <= nv_area_s1_q;
      nv_wpm_s1_q <= nv_wpm;
      nv_wpm_s2_q <= nv_wpm_s1_q;
    end
  end

  // ***************************************
  // bus slave handshake
  // ***************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= req;
      if (req && avs_read) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;

  // ***************************************
  // control register
  // ***************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_ok && sel_ctrl) begin
        ctrl_q <= ctrl_new | (ctrl_q & (32'h1 << FOCR_RLD_BIT));
      end else if (load_strobe) begin
        ctrl_q[FOCR_RLD_BIT] <= 1'b0;
      end
    end
  end

  // ***************************************
  // option and area registers
  // ***************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opt_q <= '0;
      area_q <= '0;
      wpm_q <= FOCR_WPM_NONE[SECTORS-1:0];
    end else if (ce) begin
      if (load_strobe) begin
        opt_q <= nv_opt_s2_q;
        area_q <= nv_area_s2_q;
        wpm_q <= nv_wpm_s2_q;
      end else if (wr_ok) begin
        if (sel_opt) begin
          opt_q <= opt_new[15:0];
        end
        if (sel_area) begin
          area_q <= {area_new[12:8], area_new[4:0]};
        end
        if (sel_wpm) begin
          wpm_q <= wpm_new[SECTORS-1:0];
        end
      end
    end
  end

  // ***************************************
  // operation gating
  // ***************************************
  // software must keep at most one select set; all reach the guard as is, which gates only sector and mass erase
  focr_op_t op_sel;
  assign op_sel.program_select = ctrl_q[FOCR_PG_BIT];
  assign op_sel.page_erase_select = ctrl_q[FOCR_PER_BIT];
  assign op_sel.sector_erase_select = ctrl_q[FOCR_SER_BIT];
  assign op_sel.mass_erase_select = ctrl_q[FOCR_MER_BIT];

  focr_guard #(.SECTORS(SECTORS)) u_guard (
    .op(op_sel),
    .sector(target_sector),
    .info_target(target_info),
    .wpm(wpm_q),
    .sector_open(),
    .allowed(op_allowed)
  );

  // ***************************************
  // decoded option outputs
  // ***************************************
  assign write_protect_mask = wpm_q;
  // boot pin high together with a set select bit picks the loader
  assign boot_from_system = boot_s2_q & opt_q.boot_select_bit;
  assign reset_pin_function = opt_q.reset_pin_function;
  assign window_dog_soft_start = opt_q.window_dog_soft_start;
  assign independent_dog_soft_start =
    opt_q.independent_dog_soft_start;
  assign brownout_enable = opt_q.brownout_enable;
  // level forced to lowest code while detection is off
  assign brownout_level = opt_q.brownout_enable ?
    opt_q.brownout_level : 3'h0;
  assign read_protect_active =
    (opt_q.read_protect_level != FOCR_RDP_OPEN);
  assign area_first_addr =
    32'(area_q.protected_area_start) << FOCR_STEP_SHIFT;
  assign area_last_addr =
    ((32'(area_q.protected_area_end) + 32'h1) << FOCR_STEP_SHIFT)
    - 32'h1;
  assign option_reload_reset = load_busy;
endmodule

// File: verif/focr_props.sv
`timescale 1ns/10ps
// ************************
// port-level checks
// ************************
module focr_props #(
  parameter int unsigned SECTORS = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] target_sector,
  input wire logic target_info,
  input focr_pkg::focr_op_t op_allowed,
  input wire logic [SECTORS-1:0] write_protect_mask,
  input wire logic brownout_enable,
  input wire logic [2:0] brownout_level,
  input wire logic [31:0] area_first_addr,
  input wire logic [31:0] area_last_addr,
  input wire logic option_reload_reset
);
  import focr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence pend_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // busy spans the four fetch cycles plus the cycle that loads
  sequence load_s;
    option_reload_reset [*5] ##1 !option_reload_reset;
  endsequence
  chk_wait_one: assert property (pend_s |=> !avs_waitrequest)
    else $error("bus answer not after one wait");
  chk_reload_len: assert property (
    $rose(option_reload_reset) && ce |-> load_s)
    else $error("reload busy length wrong");
  chk_area_first: assert property (area_first_addr[10:0] == 11'h000)
    else $error("area start not 2k aligned");
  chk_area_last: assert property (area_last_addr[10:0] == 11'h7ff)
    else $error("area end not at step top");
  chk_bor_gate: assert property (
    !brownout_enable |-> brownout_level == 3'h0)
    else $error("level shown while detection off");
  chk_mass_block: assert property (
    op_allowed.mass_erase_select |-> &write_protect_mask)
    else $error("mass erase under protection");
  chk_sector_wp: assert property (
    op_allowed.sector_erase_select |-> write_protect_mask[target_sector])
    else $error("sector erase on protected sector");
  chk_info_safe: assert property (
    target_info |-> !op_allowed.sector_erase_select)
    else $error("sector erase reaches info memory");
  chk_info_mass: assert property (
    target_info |-> !op_allowed.mass_erase_select)
    else $error("mass erase reaches info memory");
endmodule

// File: verif/focr_top_tb.sv
`timescale 1ns/10ps
module focr_top_tb;
  import focr_pkg::*;
  localparam int unsigned SECTORS = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd, area_first_addr, area_last_addr;
  logic avs_waitrequest, boot_from_system, reset_pin_function;
  logic window_dog_soft_start, independent_dog_soft_start;
  logic brownout_enable, read_protect_active, option_reload_reset;
  logic [2:0] brownout_level;
  focr_opt_t nv_opt = focr_opt_t'(16'hdbaa);
  focr_area_t nv_area = focr_area_t'(10'h061);
  logic [SECTORS-1:0] nv_wpm = 16'hffff;
  logic [SECTORS-1:0] write_protect_mask;
  logic boot_pin = 1'b1;
  logic [3:0] target_sector = 4'h3;
  logic target_info = 1'b0;
  focr_op_t op_allowed;
  int miscompares = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  focr_top #(.SECTORS(SECTORS)) uut (
    .clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .nv_opt(nv_opt), .nv_area(nv_area), .nv_wpm(nv_wpm),
    .boot_pin(boot_pin), .target_sector(target_sector),
    .target_info(target_info), .op_allowed(op_allowed),
    .write_protect_mask(write_protect_mask),
    .boot_from_system(boot_from_system),
    .reset_pin_function(reset_pin_function),
    .window_dog_soft_start(window_dog_soft_start),
    .independent_dog_soft_start(independent_dog_soft_start),
    .brownout_enable(brownout_enable), .brownout_level(brownout_level),
    .read_protect_active(read_protect_active),
    .area_first_addr(area_first_addr), .area_last_addr(area_last_addr),
    .option_reload_reset(option_reload_reset));

  // ************************
  // shared tasks
  // ************************
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    while (option_reload_reset !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      conclude();
    end
    repeat (3) @(posedge clk);
  endtask

  // ************************
  // scenarios
  // ************************
  task automatic t_load();
    rdchk(FOCR_OPT_OFS, 32'h0000_dbaa);
    rdchk(FOCR_AREA_OFS, 32'h0000_0301);
    check(area_first_addr, 32'h0000_0800);
    check(area_last_addr, 32'h0000_1fff);
    check(read_protect_active, 1'b0);
    check(brownout_level, 3'h5);
    check(boot_from_system, 1'b1);
    rdchk(FOCR_LOAD_OFS, 32'h0);
  endtask
  task automatic t_opt();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {16'hffff, i[0], i[1], i[2], i[0], i[2:0], 1'b1,
           (i[0] ? 8'hab : 8'haa)};
      bus(1'b1, FOCR_OPT_OFS, d);
      rdchk(FOCR_OPT_OFS, {16'h0, d[15:0]});
      check(boot_from_system, i[0]);
      check(reset_pin_function, i[1]);
      check(window_dog_soft_start, i[2]);
      check(independent_dog_soft_start, i[0]);
      check(brownout_level, i[2:0]);
      check(brownout_enable, 1'b1);
      check(read_protect_active, i[0]);
    end
    bus(1'b1, FOCR_OPT_OFS, 32'h0000_0e55);
    rdchk(FOCR_OPT_OFS, 32'h0000_0e55);
    check(brownout_level, 3'h0);
    check(brownout_enable, 1'b0);
  endtask
  task automatic t_area();
    bus(1'b1, FOCR_AREA_OFS, 32'hffff_ffff);
    rdchk(FOCR_AREA_OFS, 32'h0000_1f1f);
    check(area_first_addr, 32'h0000_f800);
    check(area_last_addr, 32'h0000_ffff);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0);
  endtask
  task automatic t_ops();
    int unsigned b[4] = '{0, 1, 11, 2};
    bus(1'b1, FOCR_WPM_OFS, 32'h0000_ffff);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, FOCR_CTRL_OFS, 32'h1 << b[k]);
      rdchk(FOCR_CTRL_OFS, 32'h1 << b[k]);
      check(op_allowed, 4'b1000 >> k);
    end
    bus(1'b1, FOCR_CTRL_OFS, 32'hf7ff_f7f8);
    rdchk(FOCR_CTRL_OFS, 32'h0);
    bus(1'b1, FOCR_WPM_OFS, 32'h0000_fff7);
    bus(1'b1, FOCR_CTRL_OFS, 32'h0000_0800);
    rdchk(FOCR_WPM_OFS, 32'h0000_fff7);
    check(op_allowed, 4'h0);
    bus(1'b1, FOCR_CTRL_OFS, 32'h0000_0004);
    rdchk(FOCR_CTRL_OFS, 32'h0000_0004);
    check(op_allowed, 4'h0);
    bus(1'b1, FOCR_WPM_OFS, 32'h0000_ffff);
    target_info <= 1'b1;
    bus(1'b1, FOCR_CTRL_OFS, 32'h0000_0800);
    rdchk(FOCR_CTRL_OFS, 32'h0000_0800);
    check(op_allowed, 4'h0);
    bus(1'b1, FOCR_CTRL_OFS, 32'h0000_0004);
    check(op_allowed, 4'h0);
    target_info <= 1'b0;
  endtask
  task automatic t_reload();
    int n;
    n = 0;
    nv_wpm <= 16'h7fff;
    bus(1'b1, FOCR_CTRL_OFS, 32'h0800_0000);
    while (option_reload_reset !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check(option_reload_reset, 1'b1);
    rdchk(FOCR_LOAD_OFS, 32'h1);
    wait_load();
    rdchk(FOCR_CTRL_OFS, 32'h0);
    rdchk(FOCR_OPT_OFS, 32'h0000_dbaa);
    rdchk(FOCR_AREA_OFS, 32'h0000_0301);
    check(write_protect_mask, 16'h7fff);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wait_load();
    t_load();
    t_opt();
    t_area();
    t_ops();
    t_reload();
    conclude();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #(100 * 5000);
    miscompares++;
    conclude();
  end
endmodule

bind focr_top focr_props #(.SECTORS(SECTORS)) u_props (
  .clk(clk), .reset(reset), .ce(ce), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .target_sector(target_sector), .target_info(target_info),
  .op_allowed(op_allowed), .write_protect_mask(write_protect_mask),
  .brownout_enable(brownout_enable), .brownout_level(brownout_level),
  .area_first_addr(area_first_addr), .area_last_addr(area_last_addr),
  .option_reload_reset(option_reload_reset));
